/* File: verilog/snf_pkg.sv */
// Constants shared by the serial memory command front end.
// Assumes a 100 MHz system clock that samples the serial pins.
`default_nettype none
package snf_pkg;
    // System clock rate and power-up wait.
    localparam int CLK_MHZ      = 100;
    localparam int PWR_WAIT_US  = 250;
    localparam int PWR_CYCLES   = PWR_WAIT_US * CLK_MHZ;

    // Command opcodes.
    localparam logic [7:0] OP_LATCH_SET    = 8'h06;
    localparam logic [7:0] OP_LATCH_CLEAR  = 8'h04;
    localparam logic [7:0] OP_STATUS_READ  = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_MEM_READ     = 8'h03;
    localparam logic [7:0] OP_FAST_READ    = 8'h0b;
    localparam logic [7:0] OP_MEM_WRITE    = 8'h02;
    localparam logic [7:0] OP_SLEEP        = 8'hb9;
    localparam logic [7:0] OP_IDENT_READ   = 8'h9f;

    // Status register layout.
    localparam int         STAT_LATCH_BIT  = 1;
    localparam logic [7:0] STAT_WR_MASK    = 8'h8c;
    localparam logic [7:0] STAT_RESET      = 8'h40;
    localparam logic [7:0] STAT_FIXED      = 8'h40;

    // Write stream buffer.
    localparam int FIFO_DEPTH = 32;
    localparam int ADDR_W     = 16;
    localparam int FIFO_WIDTH = ADDR_W + 8;

    // Link-side states.
    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01,
        ST_OPC   = 7'h02,
        ST_ADDR  = 7'h04,
        ST_WDATA = 7'h08,
        ST_SWR   = 7'h10,
        ST_SRD   = 7'h20,
        ST_SKIP  = 7'h40
    } snf_state_t;
endpackage
`default_nettype wire

/* File: verilog/snf_sync.sv */
// Two-stage synchroniser for a bundle of asynchronous pin levels.
// Assumes the inputs are plain levels; only the second stage is used.
`default_nettype none
`timescale 1ns/100ps
module snf_sync #(
    // Reset level of each stage; match it to each pin's idle level.
    parameter int               WIDTH   = 3,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock and reset
    input  wire logic             mclk_in,
    input  wire logic             rst_in,
    // Levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule // snf_sync
`default_nettype wire

/* File: verilog/snf_fifo.sv */
// Synchronous FIFO with valid/ready on both sides and a registered
// output stage. Assumes one clock for both sides.
`default_nettype none
`timescale 1ns/100ps
module snf_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input  wire logic             mclk_in,
    input  wire logic             rst_in,
    // Fill side
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    // Drain side
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic      [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             ov_q, ov_d;
    logic [WIDTH-1:0] od_q, od_d;
    logic             push, pop;

    assign in_ready_out  = (cnt_q != FULL);
    assign out_valid_out = ov_q;
    assign out_data_out  = od_q;
    assign push = in_valid_in && in_ready_out;
    // The output stage refills whenever it is empty or being drained.
    assign pop  = (cnt_q != '0) && (!ov_q || out_ready_in);

    always_comb begin
        wr_d  = push ? wr_q + 1'b1 : wr_q;
        rd_d  = pop ? rd_q + 1'b1 : rd_q;
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
        ov_d = ov_q;
        od_d = od_q;
        if (pop) begin
            ov_d = 1'b1;
            od_d = mem_q[rd_q];
        end else if (out_ready_in) begin
            ov_d = 1'b0;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (push) begin
            mem_q[wr_q] <= in_data_in;
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
            ov_q  <= 1'b0;
            od_q  <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
            ov_q  <= ov_d;
            od_q  <= od_d;
        end
    end
endmodule // snf_fifo
`default_nettype wire

/* File: verilog/snf_front.sv */
// Serial slave command front end of a 64K x 8 byte memory.
// Assumes the master clock is far slower than mclk_in so that every
// serial clock level lasts several system cycles after synchronising.
`default_nettype none
`timescale 1ns/100ps
// Contract
// - Modes 0 and 3, sample rise, shift fall
// - Clock level at select picks mode
// - Mode 3 counts rises after first toggle
// - First eight bits form the opcode
// - One opcode per selection period
// - Deselected: ignore input, output tristated
// - Bad opcode: ignore until next select
// - All bytes shifted most significant first
// - Memory commands carry two address bytes
// - Decode latch set, clear, status write
// - Decode status read, read, fast read
// - Decode memory write, sleep, ident read
// - Latch cleared at reset, set by command
// - Writes blocked while latch is clear
// - Status write data leaves latch flag alone
// - Deselect clears latch after write commands
// - Eight-bit status shows latch state
// - Latch flag at status bit one
module snf_front #(
    parameter int POWERUP_CYCLES = snf_pkg::PWR_CYCLES
) (
    // Clock and reset
    input  wire logic        mclk_in,
    input  wire logic        rst_in,
    // Serial pins
    input  wire logic        cs_n_in,
    input  wire logic        sck_in,
    input  wire logic        si_in,
    output logic             so_out,
    output logic             so_oe_out,
    // Decoded commands
    output logic             cmd_valid_out,
    output logic [7:0]       cmd_code_out,
    output logic             addr_valid_out,
    output logic [15:0]      addr_out,
    // Write byte stream, address above data
    output logic             wr_valid_out,
    input  wire logic        wr_ready_in,
    output logic [23:0]      wr_data_out,
    output logic             wr_drop_out,
    // State
    output logic [7:0]       status_out,
    output logic             ready_out
);
    localparam int PW = $clog2(POWERUP_CYCLES + 1);
    localparam logic [PW-1:0] PWR_END = PW'(POWERUP_CYCLES);

    logic [2:0]  pins_s;
    logic        cs_s, sck_s, si_s;
    logic        sck_p_q, cs_p_q;
    logic        rise, fall, cs_fall, cs_rise;

    // Chip select resets high so that reset makes no false select edge.
    snf_sync #(.WIDTH(3), .RST_VAL(3'h4)) u_sync (
        .mclk_in  (mclk_in),
        .rst_in   (rst_in),
        .async_in ({cs_n_in, sck_in, si_in}),
        .sync_out (pins_s)
    );
    assign cs_s  = pins_s[2];
    assign sck_s = pins_s[1];
    assign si_s  = pins_s[0];

    assign rise    = sck_s && !sck_p_q && !cs_s;
    assign fall    = !sck_s && sck_p_q && !cs_s;
    assign cs_fall = !cs_s && cs_p_q;
    assign cs_rise = cs_s && !cs_p_q;

    snf_pkg::snf_state_t state_q, state_d;
    logic [PW-1:0] pwr_q, pwr_d;
    logic          ready_q, ready_d;
    logic          mode3_q, mode3_d;
    logic          armed_q, armed_d;
    logic [2:0]    bit_q, bit_d;
    logic [7:0]    sh_q, sh_d;
    logic [7:0]    op_q, op_d;
    logic          abyte_q, abyte_d;
    logic [15:0]   addr_q, addr_d;
    logic          latch_q, latch_d;
    logic          clr_pend_q, clr_pend_d;
    logic [7:0]    stat_q, stat_d;
    logic [7:0]    out_q, out_d;
    logic          so_q, so_d;
    logic          oe_q, oe_d;
    logic          cmdv_q, cmdv_d;
    logic          addrv_q, addrv_d;
    logic          drop_q, drop_d;
    logic          push;
    logic          fifo_ready;
    logic [7:0]    byte_w;
    logic          byte_done;
    logic          op_known;
    logic [7:0]    stat_view;

    assign byte_w    = {sh_q[6:0], si_s};
    assign byte_done = rise && armed_q && (bit_q == 3'h7);
    // Eight-bit status, latch at bit one.
    assign stat_view = (stat_q & snf_pkg::STAT_WR_MASK)
                     | snf_pkg::STAT_FIXED
                     | (8'h01 << snf_pkg::STAT_LATCH_BIT) & {8{latch_q}};

    always_comb begin
        case (byte_w)
            snf_pkg::OP_LATCH_SET, snf_pkg::OP_LATCH_CLEAR,
            snf_pkg::OP_STATUS_WRITE, snf_pkg::OP_STATUS_READ,
            snf_pkg::OP_MEM_READ, snf_pkg::OP_FAST_READ,
            snf_pkg::OP_MEM_WRITE, snf_pkg::OP_SLEEP,
            snf_pkg::OP_IDENT_READ: op_known = 1'b1;
            default:                op_known = 1'b0;
        endcase
    end

    always_comb begin
        state_d    = state_q;
        pwr_d      = (pwr_q == PWR_END) ? pwr_q : pwr_q + 1'b1;
        ready_d    = (pwr_q == PWR_END);
        mode3_d    = mode3_q;
        armed_d    = armed_q;
        bit_d      = bit_q;
        sh_d       = sh_q;
        op_d       = op_q;
        abyte_d    = abyte_q;
        addr_d     = addr_q;
        latch_d    = latch_q;
        clr_pend_d = clr_pend_q;
        stat_d     = stat_q;
        out_d      = out_q;
        so_d       = so_q;
        cmdv_d     = 1'b0;
        addrv_d    = 1'b0;
        drop_d     = 1'b0;
        push       = 1'b0;
        // Mode 3 arms on the first falling toggle.
        if (fall) begin
            armed_d = 1'b1;
        end
        if (rise && armed_q) begin
            bit_d = bit_q + 3'h1;
            sh_d  = byte_w;
        end
        case (state_q)
            snf_pkg::ST_IDLE: begin
                // Selection is honoured only after power-up.
                if (cs_fall && ready_q) begin
                    mode3_d = sck_s;
                    armed_d = !sck_s;
                    bit_d   = 3'h0;
                    abyte_d = 1'b0;
                    state_d = snf_pkg::ST_OPC;
                end
            end
            snf_pkg::ST_OPC: begin
                if (byte_done) begin
                    op_d = byte_w;
                    cmdv_d = op_known;
                    state_d = snf_pkg::ST_SKIP;
                    case (byte_w)
                        // Only the set command raises the latch.
                        snf_pkg::OP_LATCH_SET: latch_d = 1'b1;
                        // Clear and status write arm the clear.
                        snf_pkg::OP_LATCH_CLEAR: clr_pend_d = 1'b1;
                        snf_pkg::OP_STATUS_WRITE: begin
                            clr_pend_d = 1'b1;
                            state_d    = snf_pkg::ST_SWR;
                        end
                        snf_pkg::OP_STATUS_READ: begin
                            out_d   = stat_view;
                            state_d = snf_pkg::ST_SRD;
                        end
                        snf_pkg::OP_MEM_READ, snf_pkg::OP_FAST_READ:
                            state_d = snf_pkg::ST_ADDR;
                        // Memory write arms the clear too.
                        snf_pkg::OP_MEM_WRITE: begin
                            clr_pend_d = 1'b1;
                            state_d    = snf_pkg::ST_ADDR;
                        end
                        default: state_d = snf_pkg::ST_SKIP;
                    endcase
                end
            end
            snf_pkg::ST_ADDR: begin
                // Two address bytes, high byte first.
                if (byte_done) begin
                    addr_d  = {addr_q[7:0], byte_w};
                    abyte_d = 1'b1;
                    if (abyte_q) begin
                        addrv_d = 1'b1;
                        state_d = (op_q == snf_pkg::OP_MEM_WRITE)
                                ? snf_pkg::ST_WDATA : snf_pkg::ST_SKIP;
                    end
                end
            end
            snf_pkg::ST_WDATA: begin
                // Bytes go out only while the latch is set.
                if (byte_done && latch_q) begin
                    push   = fifo_ready;
                    drop_d = !fifo_ready;
                    addr_d = addr_q + 16'h0001;
                end
            end
            snf_pkg::ST_SWR: begin
                // Latch bit is never taken from the data.
                if (byte_done) begin
                    if (latch_q) begin
                        stat_d = byte_w & snf_pkg::STAT_WR_MASK;
                    end
                    state_d = snf_pkg::ST_SKIP;
                end
            end
            snf_pkg::ST_SRD: begin
                if (fall) begin
                    so_d  = out_q[7];
                    out_d = {out_q[6:0], out_q[7]};
                end
            end
            snf_pkg::ST_SKIP: begin
                state_d = snf_pkg::ST_SKIP;
            end
            default: state_d = snf_pkg::ST_IDLE;
        endcase
        // Deselect ends the period; a new select is needed.
        if (cs_s) begin
            state_d = snf_pkg::ST_IDLE;
        end
        // Clear the latch at the closing deselect.
        if (cs_rise && clr_pend_q) begin
            latch_d    = 1'b0;
            clr_pend_d = 1'b0;
        end
        // Drive only during a status read while selected.
        oe_d = (state_d == snf_pkg::ST_SRD);
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q    <= snf_pkg::ST_IDLE;
            pwr_q      <= '0;
            ready_q    <= 1'b0;
            sck_p_q    <= 1'b0;
            cs_p_q     <= 1'b1;
            mode3_q    <= 1'b0;
            armed_q    <= 1'b0;
            bit_q      <= 3'h0;
            sh_q       <= 8'h00;
            op_q       <= 8'h00;
            abyte_q    <= 1'b0;
            addr_q     <= 16'h0000;
            latch_q    <= 1'b0;
            clr_pend_q <= 1'b0;
            stat_q     <= snf_pkg::STAT_RESET;
            out_q      <= 8'h00;
            so_q       <= 1'b0;
            oe_q       <= 1'b0;
            cmdv_q     <= 1'b0;
            addrv_q    <= 1'b0;
            drop_q     <= 1'b0;
        end else begin
            state_q    <= state_d;
            pwr_q      <= pwr_d;
            ready_q    <= ready_d;
            sck_p_q    <= sck_s;
            cs_p_q     <= cs_s;
            mode3_q    <= mode3_d;
            armed_q    <= armed_d;
            bit_q      <= bit_d;
            sh_q       <= sh_d;
            op_q       <= op_d;
            abyte_q    <= abyte_d;
            addr_q     <= addr_d;
            latch_q    <= latch_d;
            clr_pend_q <= clr_pend_d;
            stat_q     <= stat_d;
            out_q      <= out_d;
            so_q       <= so_d;
            oe_q       <= oe_d;
            cmdv_q     <= cmdv_d;
            addrv_q    <= addrv_d;
            drop_q     <= drop_d;
        end
    end

    // The serial link cannot be stalled, so a full buffer drops bytes.
    snf_fifo #(
        .WIDTH(snf_pkg::FIFO_WIDTH),
        .DEPTH(snf_pkg::FIFO_DEPTH)
    ) u_fifo (
        .mclk_in       (mclk_in),
        .rst_in        (rst_in),
        .in_valid_in   (push),
        .in_ready_out  (fifo_ready),
        .in_data_in    ({addr_q, byte_w}),
        .out_valid_out (wr_valid_out),
        .out_ready_in  (wr_ready_in),
        .out_data_out  (wr_data_out)
    );

    assign so_out         = so_q;
    assign so_oe_out      = oe_q;
    assign cmd_valid_out  = cmdv_q;
    assign cmd_code_out   = op_q;
    assign addr_valid_out = addrv_q;
    assign addr_out       = addr_q;
    assign wr_drop_out    = drop_q;
    assign status_out     = stat_view;
    assign ready_out      = ready_q;

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    sequence s_srd_start;
        state_q == snf_pkg::ST_OPC && byte_done
            && byte_w == snf_pkg::OP_STATUS_READ && !cs_s;
    endsequence

    chk_oe_deselect: assert property (cs_s |=> !so_oe_out)
        else $error("output enabled while deselected");
    chk_mode_select: assert property (state_q == snf_pkg::ST_IDLE
        && cs_fall && ready_q |=> mode3_q == $past(sck_s))
        else $error("mode not taken from clock level");
    chk_mode3_arm: assert property (state_q == snf_pkg::ST_IDLE
        && cs_fall && ready_q && sck_s |=> !armed_q)
        else $error("mode 3 armed before toggle");
    chk_latch_set: assert property (state_q == snf_pkg::ST_OPC
        && byte_done && byte_w == snf_pkg::OP_LATCH_SET
        |=> latch_q)
        else $error("latch not set by set command");
    chk_latch_clear: assert property (cs_rise && clr_pend_q
        |=> !latch_q ##1 !latch_q)
        else $error("latch not cleared at deselect");
    chk_bad_opcode: assert property (state_q == snf_pkg::ST_OPC
        && byte_done && !op_known && !cs_s
        |=> state_q == snf_pkg::ST_SKIP && !cmd_valid_out)
        else $error("unknown opcode not discarded");
    chk_one_opcode: assert property (state_q == snf_pkg::ST_SKIP
        |=> state_q inside {snf_pkg::ST_SKIP, snf_pkg::ST_IDLE})
        else $error("second opcode within one period");
    chk_push_gated: assert property (push |-> latch_q
        && state_q == snf_pkg::ST_WDATA)
        else $error("write byte passed with latch clear");
    chk_status_fixed: assert property (status_out[6] && !status_out[0]
        && status_out[snf_pkg::STAT_LATCH_BIT] == latch_q)
        else $error("status fixed bits or latch flag wrong");
    chk_swr_latch: assert property (state_q == snf_pkg::ST_SWR
        && byte_done |=> latch_q == $past(latch_q))
        else $error("status write changed latch flag");
    chk_srd_load: assert property (s_srd_start
        |=> state_q == snf_pkg::ST_SRD
        && out_q == $past(stat_view) ##1 so_oe_out)
        else $error("status read did not load output");
    chk_pwr_ignore: assert property (!ready_q
        |=> state_q == snf_pkg::ST_IDLE)
        else $error("selection accepted during power-up");
endmodule // snf_front
`default_nettype wire

/* File: dv/snf_master_model.sv */
// Serial bus master model that drives the front end's pins.
// Assumes the bench calls its tasks; timing runs from clk_in falls.
`default_nettype none
`timescale 1ns/100ps
module snf_master_model (
    // Clock
    input  wire logic clk_in,
    // Serial pins
    output logic      cs_n_out,
    output logic      sck_out,
    output logic      si_out,
    input  wire logic so_in
);
    logic mode3_q;
    initial begin
        cs_n_out = 1'b1;
        sck_out  = 1'b0;
        si_out   = 1'b0;
        mode3_q  = 1'b0;
    end
    // Half a serial clock period is 40 ns.
    task automatic half();
        repeat (4) @(negedge clk_in);
    endtask
    task automatic sel(input logic m3);
        mode3_q  = m3;
        sck_out  = m3;
        half();
        cs_n_out = 1'b0;
        half();
    endtask
    // Bits go out most significant first
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sck_out = 1'b0;
            si_out  = tx[i];
            half();
            sck_out = 1'b1;
            rx[i]   = so_in;
            half();
        end
    endtask
    task automatic desel();
        half();
        sck_out  = mode3_q;
        half();
        cs_n_out = 1'b1;
        // A released data line must not keep its last level.
        si_out   = ~si_out;
        half();
    endtask
endmodule // snf_master_model
`default_nettype wire

/* File: dv/tb_top.sv */
// Self-checking bench for the serial command front end.
// Assumes the master model on the pins and a bench-held drain side.
`default_nettype none
`timescale 1ns/100ps
module tb_top;
    logic        mclk_in, rst_in, cs_n, sck, si, so, so_oe;
    logic        cmd_v, addr_v, wr_v, wr_rdy, drop, rdy;
    logic [7:0]  cmd, stat, rx, last_cmd;
    logic [15:0] addr;
    logic [23:0] wr_d;
    int          err_count = 0, n_compared = 0, n_cmd = 0, n_drop = 0;
    int          n_adv = 0;

    snf_front #(.POWERUP_CYCLES(200)) DUT (
        .mclk_in(mclk_in), .rst_in(rst_in), .cs_n_in(cs_n),
        .sck_in(sck), .si_in(si), .so_out(so), .so_oe_out(so_oe),
        .cmd_valid_out(cmd_v), .cmd_code_out(cmd),
        .addr_valid_out(addr_v), .addr_out(addr),
        .wr_valid_out(wr_v), .wr_ready_in(wr_rdy),
        .wr_data_out(wr_d), .wr_drop_out(drop),
        .status_out(stat), .ready_out(rdy));
    snf_master_model mm (.clk_in(mclk_in), .cs_n_out(cs_n),
        .sck_out(sck), .si_out(si), .so_in(so));

    always #5 mclk_in = ~mclk_in;
    always @(posedge mclk_in) begin
        if (cmd_v === 1'b1) begin
            last_cmd <= cmd;
            n_cmd    <= n_cmd + 1;
        end
        if (drop === 1'b1) begin
            n_drop <= n_drop + 1;
        end
        if (addr_v === 1'b1) begin
            n_adv <= n_adv + 1;
        end
    end

    task automatic complete_run();
        if (err_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time,
                     seen, exp);
        end
    endtask
    task automatic gap();
        repeat (16) @(negedge mclk_in);
    endtask
    task automatic op(input logic m3, input logic [7:0] c);
        mm.sel(m3);
        mm.xfer(c, rx);
        mm.desel();
        gap();
    endtask
    task automatic wait_ready();
        int n;
        for (n = 0; n < 1000 && rdy !== 1'b1; n++) @(negedge mclk_in);
        if (n == 1000) begin
            err_count++;
            complete_run();
        end
    endtask
    task automatic t_powerup();
        check(stat, 8'h40); // reset status
        op(1'b0, snf_pkg::OP_LATCH_SET);
        check(stat[1], 1'b0); // access before ready
        wait_ready();
    endtask
    task automatic t_reset();
        op(1'b0, snf_pkg::OP_LATCH_SET);
        check(stat[1], 1'b1); // latch set before reset
        rst_in = 1'b1;
        repeat (3) @(negedge mclk_in);
        rst_in = 1'b0;
        check({rdy, stat}, {1'b0, 8'h40}); // cleared by reset
        wait_ready();
        t_status(1'b0, 8'h40); // status clean after reset
    endtask
    task automatic t_status(input logic m3, input logic [7:0] exp);
        mm.sel(m3);
        mm.xfer(snf_pkg::OP_STATUS_READ, rx);
        mm.xfer(8'h00, rx);
        check(rx, exp); // status byte on the wire
        check(so_oe, 1'b1); // output driven
        mm.desel();
        gap();
        check(so_oe, 1'b0); // tristated when deselected
    endtask
    task automatic t_opcodes();
        logic [7:0] codes [9] = '{8'h02, 8'h01, 8'h03, 8'h0b, 8'hb9,
                                  8'h9f, 8'h04, 8'h05, 8'h06};
        for (int i = 0; i < 9; i++) begin
            op(i[0], codes[i]);
            check(last_cmd, codes[i]); // every opcode decoded
            check(n_cmd, i + 2); // one pulse per command
        end
        check(stat[1], 1'b1); // latch set by command
        t_status(1'b1, 8'h42); // mode three read
        op(1'b0, snf_pkg::OP_LATCH_CLEAR);
        check(stat, 8'h40); // cleared by latch clear
    endtask
    task automatic t_invalid();
        mm.sel(1'b0);
        mm.xfer(8'h55, rx);
        mm.xfer(snf_pkg::OP_LATCH_SET, rx);
        mm.xfer(snf_pkg::OP_STATUS_READ, rx);
        check(so_oe, 1'b0); // output stays off
        mm.desel();
        gap();
        check({n_cmd[7:0], stat}, {8'h0c, 8'h40}); // rest ignored
        op(1'b1, snf_pkg::OP_LATCH_SET);
        mm.sel(1'b1);
        mm.xfer(snf_pkg::OP_IDENT_READ, rx);
        mm.xfer(snf_pkg::OP_LATCH_CLEAR, rx);
        mm.desel();
        gap();
        check(stat[1], 1'b1); // second opcode not decoded
    endtask
    task automatic t_swrite();
        mm.sel(1'b1);
        mm.xfer(snf_pkg::OP_STATUS_WRITE, rx);
        mm.xfer(8'hff, rx);
        gap();
        check(stat[1], 1'b1); // flag untouched by data
        mm.desel();
        gap();
        check(stat, (8'hff & snf_pkg::STAT_WR_MASK) | 8'h40);
        mm.sel(1'b0);
        mm.xfer(snf_pkg::OP_STATUS_WRITE, rx);
        mm.xfer(8'h00, rx);
        mm.desel();
        gap();
        check(stat, 8'hcc); // blocked while latch clear
    endtask
    task automatic t_fifo();
        int n;
        int k;
        op(1'b0, snf_pkg::OP_LATCH_SET);
        mm.sel(1'b0);
        mm.xfer(snf_pkg::OP_MEM_WRITE, rx);
        mm.xfer(8'hff, rx);
        mm.xfer(8'hfe, rx);
        gap();
        check(addr, 16'hfffe); // two address bytes
        check(n_adv, 1); // one address strobe
        for (int i = 0; i < 34; i++) mm.xfer(i[7:0], rx);
        mm.desel();
        gap();
        check(stat[1], 1'b0); // cleared after write
        check(n_drop > 0 && n_drop <= 2, 1'b1); // full buffer refuses
        for (int j = 0; j < 34 - n_drop; j++) begin
            for (n = 0; n < 100 && wr_v !== 1'b1; n++) @(negedge mclk_in);
            if (n == 100) begin
                err_count++;
                complete_run();
            end
            k = j;
            check(wr_d, {16'hfffe + k[15:0], k[7:0]}); // wraps
            @(negedge mclk_in);
            // A stalled drain side must see the same word again.
            check(wr_d, {16'hfffe + k[15:0], k[7:0]}); // held
            wr_rdy = 1'b1;
            @(negedge mclk_in);
            wr_rdy = 1'b0;
        end
        gap();
        check(wr_v, 1'b0); // drained to empty
    endtask
    initial begin
        mclk_in = 1'b0;
        rst_in  = 1'b1;
        wr_rdy  = 1'b0;
        repeat (10) @(posedge mclk_in);
        @(negedge mclk_in);
        rst_in = 1'b0;
        t_powerup();
        t_status(1'b0, 8'h40);
        t_opcodes();
        t_invalid();
        t_swrite();
        t_fifo();
        t_reset();
        complete_run();
    end
endmodule // tb_top
`default_nettype wire
